// ---- common/canl_regs.vh ----
// Register map constants for the clock alarm notify block.
// Assumes word-addressed Avalon-MM access: the bus address is the register index.
`ifndef CANL_REGS_VH
`define CANL_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CANL_REG_SUPPLY   8'h02
`define CANL_REG_NTFY_A   8'h03
`define CANL_REG_MASK_A   8'h04
`define CANL_REG_RELOCK   8'h05
`define CANL_REG_LIVE_B   8'h06
`define CANL_REG_NTFY_B   8'h07
`define CANL_REG_MASK_B   8'h08
`define CANL_REG_OUT_PD   8'hc0
`define CANL_REG_PAGE     8'hff

// ----------------------------------------------------------------------------
// Page numbers
// ----------------------------------------------------------------------------
`define CANL_PG_GEN       8'h00
`define CANL_PG_MON       8'h01
`define CANL_PG_CORE      8'h03
`define CANL_PG_PLLA      8'h0a
`define CANL_PG_PLLD      8'h0d

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CANL_BIT_OSC      2
`define CANL_BIT_VIN      1
`define CANL_BIT_VCORE    2
`define CANL_BIT_VCORE_P3 0
`define CANL_BIT_RELOCK   0
`define CANL_BIT_PD       0
`define CANL_RST_BYTE     8'h00
`define CANL_RST_WORD     32'h0000_0000

`endif

// ---- hw/canl_top.v ----
// Alarm notify logic: sticky notifies, masks, paged registers, alarm pins,
// PLL re-lock and output power-down controls.
// Assumes live monitor inputs are asynchronous; registers reached over
// Avalon-MM with waitrequest, one 8-bit register per 32-bit word.
`timescale 1ns/1ps
`default_nettype none
`include "canl_regs.vh"

// Behaviour
// R01: Writing one clears that notify bit
// R02: Mask bit one enables its notify
// R03: Page register selects target of accesses
// R04: Oscillator loss notify at page0 page0_osc_loss_notify bit2
// R05: Lock/holdover notifies page0 page0_lock_holdover_notify, write-one clear
// R06: Input clock-loss notifies page1 page0_osc_loss_notify[3:0]
// R07: Drift notifies page1 page0_lock_holdover_notify, write-one clear
// R08: Host clears all four notify groups
// R09: Input supply dip at page0 reg02 bit1
// R10: Core supply dip on PLL pages, page3
// R11: Supply dip bit reads one when low
// R12: Interrupt pin low when selected notify set
// R13: Interrupt held until clearing writes
// R14: Combined lock pin high when all used locked
// R15: Per-PLL lock pins follow live lock
// R16: Oscillator loss pin covers crystal or internal
// R17: PLL pages are 0x0a to 0x0d
// R18: Register pll_output_power_down bit0 powers outputs down
// R19: Writing 0x01 then 0x00 to pll_relock_trigger re-locks
// R20: Host restores output power after re-lock
// R21: Mask 0x04 enables notifies of 0x03
// R22: Mask 0x08 enables notifies of 0x07
// R23: Live clock-loss readable page1 reg02[3:0]
// R24: Notify sets on condition, holds, zero ignored
// R25: Set wins over simultaneous clear
module canl_top #(
    parameter [3:0] PLL_USED = 4'hf
) (
    input  wire        I_CLK,
    input  wire        I_NRST,
    input  wire [7:0]  I_AVS_ADDRESS,
    input  wire        I_AVS_READ,
    input  wire        I_AVS_WRITE,
    input  wire [31:0] I_AVS_WRITEDATA,
    input  wire [3:0]  I_AVS_BYTEENABLE,
    output reg  [31:0] O_AVS_READDATA,
    output wire        O_AVS_WAITREQUEST,
    input  wire [3:0]  I_INPUT_CLOCK_LOSS,
    input  wire [7:0]  I_FREQ_DRIFT,
    input  wire [3:0]  I_PLL_UNLOCK,
    input  wire [3:0]  I_PLL_HOLDOVER,
    input  wire        I_XTAL_LOSS,
    input  wire        I_INT_OSC_LOSS,
    input  wire        I_INPUT_SUPPLY_DIP,
    input  wire        I_CORE_SUPPLY_DIP,
    output reg         O_INTR_N,
    output reg         O_ANY_UNLOCK_N,
    output reg         O_PLL_A_LOCK_N,
    output reg         O_PLL_B_LOCK_N,
    output reg         O_PLL_C_LOCK_N,
    output reg         O_PLL_D_LOCK_N,
    output reg         O_OSC_PATH_LOSS_N,
    output reg  [3:0]  O_PLL_OUT_PD,
    output reg  [3:0]  O_PLL_RELOCK
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Sticky update: set applied after the clear so an event is never lost
    function [7:0] canl_w1c;
        input [7:0] cur;
        input [7:0] set;
        input [7:0] clr;
        begin
            canl_w1c = (cur & ~clr) | set; // [R01] [R24] [R25]
        end
    endfunction

    function canl_is_pll_page;
        input [7:0] pg;
        begin
            canl_is_pll_page = (pg >= `CANL_PG_PLLA) && (pg <= `CANL_PG_PLLD); // [R17]
        end
    endfunction

    function [1:0] canl_pll_idx;
        input [7:0] pg;
        reg   [7:0] d;
        begin
            d = pg - `CANL_PG_PLLA;
            canl_pll_idx = d[1:0];
        end
    endfunction

    // Strobe for one register write on a selected page
    function canl_wr_hit;
        input       en;
        input       pg_ok;
        input [7:0] a;
        input [7:0] idx;
        begin
            canl_wr_hit = en && pg_ok && (a == idx);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    localparam LW = 24;
    wire [LW-1:0] live_in = {I_CORE_SUPPLY_DIP, I_INPUT_SUPPLY_DIP, I_INT_OSC_LOSS, I_XTAL_LOSS,
                             I_PLL_HOLDOVER, I_PLL_UNLOCK, I_FREQ_DRIFT, I_INPUT_CLOCK_LOSS};
    reg  [LW-1:0] sync1_r;
    reg  [LW-1:0] sync2_r;

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            sync1_r <= {LW{1'b0}};
            sync2_r <= {LW{1'b0}};
        end
        else
        begin
            sync1_r <= live_in;
            sync2_r <= sync1_r;
        end
    end

    wire [3:0] clk_loss   = sync2_r[3:0];
    wire [7:0] drift      = sync2_r[11:4];
    wire [3:0] unlock     = sync2_r[15:12];
    wire [3:0] holdover   = sync2_r[19:16];
    wire       osc_loss   = sync2_r[20] | sync2_r[21]; // [R16]
    wire       vin_dip    = sync2_r[22];
    wire       vcore_dip  = sync2_r[23];

    // ------------------------------------------------------------------------
    // Avalon-MM handshake
    // ------------------------------------------------------------------------
    // One wait cycle per access keeps read data registered
    reg        ack_r;
    wire       req = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req & ~ack_r;
    wire       wr_en = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
    wire [7:0] wdat  = I_AVS_WRITEDATA[7:0];
    wire [7:0] addr  = I_AVS_ADDRESS;

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg  [7:0]  page_r;
    reg         osc_ntfy_r;
    reg  [7:0]  lock_ho_ntfy_r;
    reg  [3:0]  cl_ntfy_r;
    reg  [7:0]  drift_ntfy_r;
    reg  [7:0]  mask_p0a_r;
    reg  [7:0]  mask_p0b_r;
    reg  [7:0]  mask_p1a_r;
    reg  [7:0]  mask_p1b_r;
    reg  [31:0] relock_r;
    reg  [31:0] out_pd_r;

    wire        on_p0   = (page_r == `CANL_PG_GEN);  // [R03]
    wire        on_p1   = (page_r == `CANL_PG_MON);  // [R03]
    wire        on_pll  = canl_is_pll_page(page_r);
    wire [1:0]  pidx    = canl_pll_idx(page_r);
    wire [4:0]  pbase   = {pidx, 3'b000};

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------
    // Decoded once so clear strobes and register updates agree
    wire        wr_page      = canl_wr_hit(wr_en, 1'b1, addr, `CANL_REG_PAGE); // [R03]
    wire        wr_p0_ntfy_a = canl_wr_hit(wr_en, on_p0, addr, `CANL_REG_NTFY_A);
    wire        wr_p0_ntfy_b = canl_wr_hit(wr_en, on_p0, addr, `CANL_REG_NTFY_B);
    wire        wr_p1_ntfy_a = canl_wr_hit(wr_en, on_p1, addr, `CANL_REG_NTFY_A);
    wire        wr_p1_ntfy_b = canl_wr_hit(wr_en, on_p1, addr, `CANL_REG_NTFY_B);
    wire        wr_p0_mask_a = canl_wr_hit(wr_en, on_p0, addr, `CANL_REG_MASK_A);
    wire        wr_p0_mask_b = canl_wr_hit(wr_en, on_p0, addr, `CANL_REG_MASK_B);
    wire        wr_p1_mask_a = canl_wr_hit(wr_en, on_p1, addr, `CANL_REG_MASK_A);
    wire        wr_p1_mask_b = canl_wr_hit(wr_en, on_p1, addr, `CANL_REG_MASK_B);
    wire        wr_out_pd    = canl_wr_hit(wr_en, on_pll, addr, `CANL_REG_OUT_PD);

    // Write-one-clear strobes per group
    wire [7:0]  clr_osc   = wr_p0_ntfy_a ? wdat : `CANL_RST_BYTE; // [R04]
    wire [7:0]  clr_lkho  = wr_p0_ntfy_b ? wdat : `CANL_RST_BYTE; // [R05]
    wire [7:0]  clr_cl    = wr_p1_ntfy_a ? wdat : `CANL_RST_BYTE; // [R06]
    wire [7:0]  clr_drift = wr_p1_ntfy_b ? wdat : `CANL_RST_BYTE; // [R07]

    wire [7:0]  osc_vec_nxt   = canl_w1c({5'h00, osc_ntfy_r, 2'h0}, {5'h00, osc_loss, 2'h0}, clr_osc);
    wire [7:0]  lkho_nxt      = canl_w1c(lock_ho_ntfy_r, {holdover, unlock}, clr_lkho);
    wire [7:0]  cl_vec_nxt    = canl_w1c({4'h0, cl_ntfy_r}, {4'h0, clk_loss}, clr_cl);
    wire [7:0]  drift_nxt     = canl_w1c(drift_ntfy_r, drift, clr_drift);

    wire        relock_wr = canl_wr_hit(wr_en, on_pll, addr, `CANL_REG_RELOCK);
    wire        old_rl    = relock_r[pbase + `CANL_BIT_RELOCK];

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            ack_r          <= 1'b0;
            page_r         <= `CANL_RST_BYTE;
            osc_ntfy_r     <= 1'b0;
            lock_ho_ntfy_r <= `CANL_RST_BYTE;
            cl_ntfy_r      <= 4'h0;
            drift_ntfy_r   <= `CANL_RST_BYTE;
            mask_p0a_r     <= `CANL_RST_BYTE;
            mask_p0b_r     <= `CANL_RST_BYTE;
            mask_p1a_r     <= `CANL_RST_BYTE;
            mask_p1b_r     <= `CANL_RST_BYTE;
            relock_r       <= `CANL_RST_WORD;
            out_pd_r       <= `CANL_RST_WORD;
            O_PLL_RELOCK   <= 4'h0;
        end
        else
        begin
            ack_r          <= req & ~ack_r;
            osc_ntfy_r     <= osc_vec_nxt[`CANL_BIT_OSC];
            lock_ho_ntfy_r <= lkho_nxt;
            cl_ntfy_r      <= cl_vec_nxt[3:0];
            drift_ntfy_r   <= drift_nxt;
            // Re-lock outputs are single-cycle pulses
            O_PLL_RELOCK   <= 4'h0;
            // Page register answers on every page
            if (wr_page)
                page_r <= wdat; // [R03]
            if (wr_p0_mask_a)
                mask_p0a_r <= wdat; // [R02]
            if (wr_p0_mask_b)
                mask_p0b_r <= wdat; // [R02]
            if (wr_p1_mask_a)
                mask_p1a_r <= wdat; // [R21]
            if (wr_p1_mask_b)
                mask_p1b_r <= wdat; // [R22]
            if (relock_wr)
            begin
                relock_r[pbase +: 8] <= wdat;
                // Re-lock starts on the 1 to 0 step of the trigger
                if (old_rl && !wdat[`CANL_BIT_RELOCK])
                    O_PLL_RELOCK[pidx] <= 1'b1; // [R19]
            end
            if (wr_out_pd)
                out_pd_r[pbase +: 8] <= wdat; // [R18]
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    reg [7:0] rd_byte;

    always @*
    begin
        rd_byte = `CANL_RST_BYTE;
        if (addr == `CANL_REG_PAGE)
            rd_byte = page_r;
        else if (on_p0)
        begin
            case (addr)
                `CANL_REG_SUPPLY:
                begin
                    rd_byte[`CANL_BIT_VIN] = vin_dip;  // [R09] [R11]
                    rd_byte[`CANL_BIT_OSC] = osc_loss;
                end
                `CANL_REG_NTFY_A: rd_byte[`CANL_BIT_OSC] = osc_ntfy_r; // [R04]
                `CANL_REG_MASK_A: rd_byte = mask_p0a_r;
                `CANL_REG_LIVE_B: rd_byte = {holdover, unlock};
                `CANL_REG_NTFY_B: rd_byte = lock_ho_ntfy_r; // [R05]
                `CANL_REG_MASK_B: rd_byte = mask_p0b_r;
                default:          rd_byte = `CANL_RST_BYTE;
            endcase
        end
        else if (on_p1)
        begin
            case (addr)
                `CANL_REG_SUPPLY: rd_byte[3:0] = clk_loss; // [R23]
                `CANL_REG_NTFY_A: rd_byte[3:0] = cl_ntfy_r; // [R06]
                `CANL_REG_MASK_A: rd_byte = mask_p1a_r;
                `CANL_REG_LIVE_B: rd_byte = drift;
                `CANL_REG_NTFY_B: rd_byte = drift_ntfy_r; // [R07]
                `CANL_REG_MASK_B: rd_byte = mask_p1b_r;
                default:          rd_byte = `CANL_RST_BYTE;
            endcase
        end
        // Core supply status is mirrored on page 3
        else if (page_r == `CANL_PG_CORE)
        begin
            if (addr == `CANL_REG_SUPPLY)
                rd_byte[`CANL_BIT_VCORE_P3] = vcore_dip; // [R10] [R11]
        end
        else if (on_pll && PLL_USED[pidx])
        begin
            case (addr)
                `CANL_REG_SUPPLY: rd_byte[`CANL_BIT_VCORE] = vcore_dip; // [R10] [R11]
                `CANL_REG_RELOCK: rd_byte = relock_r[pbase +: 8];
                `CANL_REG_OUT_PD: rd_byte = out_pd_r[pbase +: 8];
                default:          rd_byte = `CANL_RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Read data and alarm pins
    // ------------------------------------------------------------------------
    // Interrupt is only released by W1C writes or mask writes, since notifies are sticky
    wire any_sel = (osc_ntfy_r & mask_p0a_r[`CANL_BIT_OSC]) | (|(lock_ho_ntfy_r & mask_p0b_r))
                 | (|({4'h0, cl_ntfy_r} & mask_p1a_r)) | (|(drift_ntfy_r & mask_p1b_r)); // [R02] [R21] [R22]
    // PLLs left unused never pull the combined lock pin low
    wire [3:0] used_unlock = unlock & PLL_USED;
    integer k;

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_AVS_READDATA    <= `CANL_RST_WORD;
            O_INTR_N          <= 1'b1;
            O_ANY_UNLOCK_N    <= 1'b1;
            O_PLL_A_LOCK_N    <= 1'b1;
            O_PLL_B_LOCK_N    <= 1'b1;
            O_PLL_C_LOCK_N    <= 1'b1;
            O_PLL_D_LOCK_N    <= 1'b1;
            O_OSC_PATH_LOSS_N <= 1'b1;
            O_PLL_OUT_PD      <= 4'h0;
        end
        else
        begin
            if (I_AVS_READ & ~ack_r)
                O_AVS_READDATA <= {24'h000000, rd_byte};
            O_INTR_N          <= ~any_sel;      // [R12] [R13]
            O_ANY_UNLOCK_N    <= ~|used_unlock; // [R14]
            O_PLL_A_LOCK_N    <= ~unlock[0];    // [R15]
            O_PLL_B_LOCK_N    <= ~unlock[1];    // [R15]
            O_PLL_C_LOCK_N    <= ~unlock[2];    // [R15]
            O_PLL_D_LOCK_N    <= ~unlock[3];    // [R15]
            O_OSC_PATH_LOSS_N <= ~osc_loss;     // [R16]
            // Power-down pins follow bit 0 of each PLL page register
            for (k = 0; k < 4; k = k + 1)
                O_PLL_OUT_PD[k] <= out_pd_r[8*k + `CANL_BIT_PD]; // [R18]
        end
    end

endmodule
`default_nettype wire

// ---- sim/canl_host_model.sv ----
// Host processor model: Avalon-MM master plus the clear and re-lock routines.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module canl_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output var  logic [7:0]  o_address = 8'h00,
    output var  logic        o_read = 1'b0,
    output var  logic        o_write = 1'b0,
    output var  logic [31:0] o_writedata = 32'h0,
    output var  logic [3:0]  o_byteenable = 4'h1,
    output var  logic        o_hung = 1'b0
);
    // ------------------------------------------------------------------
    // Bus cycle: hold request until waitrequest samples low, bounded wait
    // ------------------------------------------------------------------
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be,
                        output logic [7:0] q);
        int n;
        o_address <= a;
        o_writedata <= {24'($urandom), d};
        o_byteenable <= be;
        if (rd) o_read <= 1'b1;
        else o_write <= 1'b1;
        @(posedge i_clk);
        for (n = 0; i_waitrequest && n < 64; n++) @(posedge i_clk);
        q = i_readdata[7:0];
        o_read <= 1'b0;
        o_write <= 1'b0;
        if (n >= 64) o_hung <= 1'b1;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, {3'($urandom), 1'b1}, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b1, a, 8'h00, 4'h1, q);
    endtask
    // Every group cleared in turn; 0x07 written as all ones, 0x03 written with only its used bits as one
    task automatic clear_all;
        wr(8'hff, 8'h00);
        wr(8'h03, 8'h04);
        wr(8'h07, 8'hff);
        wr(8'hff, 8'h01);
        wr(8'h03, 8'h0f);
        wr(8'h07, 8'hff);
    endtask
    task automatic relock(input logic [7:0] pg, input logic pd);
        wr(8'hff, pg);
        if (pd) wr(8'hc0, 8'h01);
        wr(8'h05, 8'h01);
        wr(8'h05, 8'h00);
        if (pd) wr(8'hc0, 8'h00);
    endtask
endmodule
`default_nettype wire

// ---- sim/canl_top_properties.sv ----
// Concurrent checks on the canl_top ports: bus answer, alarm pins, control pulses.
// Assumes one clock domain; PLL_USED is handed on from the bound instance.
`timescale 1ns/1ps
`default_nettype none
module canl_top_properties #(
    parameter [3:0] PLL_USED = 4'hf
) (
    input wire logic        I_CLK,
    input wire logic        I_NRST,
    input wire logic [7:0]  I_AVS_ADDRESS,
    input wire logic        I_AVS_READ,
    input wire logic        I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic        O_AVS_WAITREQUEST,
    input wire logic [3:0]  I_PLL_UNLOCK,
    input wire logic        I_XTAL_LOSS,
    input wire logic        I_INT_OSC_LOSS,
    input wire logic        O_INTR_N,
    input wire logic        O_ANY_UNLOCK_N,
    input wire logic        O_PLL_A_LOCK_N,
    input wire logic        O_PLL_B_LOCK_N,
    input wire logic        O_PLL_C_LOCK_N,
    input wire logic        O_PLL_D_LOCK_N,
    input wire logic        O_OSC_PATH_LOSS_N,
    input wire logic [3:0]  O_PLL_OUT_PD,
    input wire logic [3:0]  O_PLL_RELOCK
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    wire logic wr_done = I_AVS_WRITE && !O_AVS_WAITREQUEST;
    wire logic relock_wr = wr_done && I_AVS_ADDRESS == 8'h05 && !I_AVS_WRITEDATA[0];
    wire logic pd_wr = wr_done && I_AVS_ADDRESS == 8'hc0;
    wire logic osc_lost = I_XTAL_LOSS || I_INT_OSC_LOSS;
    // ------------------------------------------------------------------
    // Live pins need five steady samples: two sync flops plus output flop
    // ------------------------------------------------------------------
    sequence unlock_held_s; $stable(I_PLL_UNLOCK) [*5]; endsequence
    sequence osc_held_s; $stable(osc_lost) [*5]; endsequence
    bus_answer_a: assert property ((I_AVS_READ || I_AVS_WRITE) |-> ##[0:1] !O_AVS_WAITREQUEST)
        else $error("bus request not answered in time");
    intr_release_a: assert property ($rose(O_INTR_N) |-> $past(wr_done, 2) || $past(wr_done, 3))
        else $error("interrupt released without a host write");
    all_locked_a: assert property (unlock_held_s |-> O_ANY_UNLOCK_N == ((I_PLL_UNLOCK & PLL_USED) == 4'h0))
        else $error("combined lock pin wrong");
    lock_pins_a: assert property (unlock_held_s |->
        {O_PLL_D_LOCK_N, O_PLL_C_LOCK_N, O_PLL_B_LOCK_N, O_PLL_A_LOCK_N} == ~I_PLL_UNLOCK)
        else $error("per pll lock pin wrong");
    osc_loss_a: assert property (osc_held_s |-> O_OSC_PATH_LOSS_N == !osc_lost)
        else $error("oscillator loss pin wrong");
    relock_pulse_a: assert property (O_PLL_RELOCK != 4'h0 |=> O_PLL_RELOCK == 4'h0)
        else $error("relock pulse longer than one cycle");
    relock_cause_a: assert property (O_PLL_RELOCK != 4'h0 |-> $past(relock_wr, 1) || $past(relock_wr, 2))
        else $error("relock pulse without trigger write");
    pd_write_a: assert property (!$stable(O_PLL_OUT_PD) |-> $past(pd_wr, 1) || $past(pd_wr, 2))
        else $error("power down changed without a write");
endmodule
bind canl_top canl_top_properties #(.PLL_USED(PLL_USED)) u_props (.I_CLK, .I_NRST, .I_AVS_ADDRESS, .I_AVS_READ,
    .I_AVS_WRITE, .I_AVS_WRITEDATA, .O_AVS_WAITREQUEST, .I_PLL_UNLOCK, .I_XTAL_LOSS, .I_INT_OSC_LOSS, .O_INTR_N,
    .O_ANY_UNLOCK_N, .O_PLL_A_LOCK_N, .O_PLL_B_LOCK_N, .O_PLL_C_LOCK_N, .O_PLL_D_LOCK_N, .O_OSC_PATH_LOSS_N,
    .O_PLL_OUT_PD, .O_PLL_RELOCK);
`default_nettype wire

// ---- sim/canl_top_test.sv ----
// Self-checking bench for canl_top: host model speaks the register bus,
// the bench drives live monitor inputs and watches the alarm pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module canl_top_test;
    logic I_CLK = 1'b0, I_NRST = 1'b0, I_XTAL_LOSS = 1'b0, I_INT_OSC_LOSS = 1'b0;
    logic I_INPUT_SUPPLY_DIP = 1'b0, I_CORE_SUPPLY_DIP = 1'b0;
    logic [3:0] I_INPUT_CLOCK_LOSS = 4'h0, I_PLL_UNLOCK = 4'h0, I_PLL_HOLDOVER = 4'h0, relock_seen = 4'h0;
    logic [7:0] I_FREQ_DRIFT = 8'h00, q, ev, ex, ad;
    logic [3:0] pd_seen = 4'h0, pdx = 4'h0;
    wire logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA;
    wire logic [7:0] I_AVS_ADDRESS;
    wire logic [3:0] I_AVS_BYTEENABLE, O_PLL_OUT_PD, O_PLL_RELOCK;
    wire logic I_AVS_READ, I_AVS_WRITE, O_AVS_WAITREQUEST, O_INTR_N, O_ANY_UNLOCK_N, O_OSC_PATH_LOSS_N, hung;
    wire logic O_PLL_A_LOCK_N, O_PLL_B_LOCK_N, O_PLL_C_LOCK_N, O_PLL_D_LOCK_N;
    wire logic [3:0] lock_pins = {O_PLL_D_LOCK_N, O_PLL_C_LOCK_N, O_PLL_B_LOCK_N, O_PLL_A_LOCK_N};
    logic blip = 1'b0;
    int mismatches = 0, samples_checked = 0, g, p, pd;
    always #2.5 I_CLK = ~I_CLK;
    canl_top u_dut (.I_CLK, .I_NRST, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE,
        .O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_INPUT_CLOCK_LOSS, .I_FREQ_DRIFT, .I_PLL_UNLOCK, .I_PLL_HOLDOVER,
        .I_XTAL_LOSS, .I_INT_OSC_LOSS, .I_INPUT_SUPPLY_DIP, .I_CORE_SUPPLY_DIP, .O_INTR_N, .O_ANY_UNLOCK_N,
        .O_PLL_A_LOCK_N, .O_PLL_B_LOCK_N, .O_PLL_C_LOCK_N, .O_PLL_D_LOCK_N, .O_OSC_PATH_LOSS_N, .O_PLL_OUT_PD,
        .O_PLL_RELOCK);
    canl_host_model u_host (.i_clk(I_CLK), .i_waitrequest(O_AVS_WAITREQUEST), .i_readdata(O_AVS_READDATA),
        .o_address(I_AVS_ADDRESS), .o_read(I_AVS_READ), .o_write(I_AVS_WRITE), .o_writedata(I_AVS_WRITEDATA),
        .o_byteenable(I_AVS_BYTEENABLE), .o_hung(hung));
    // One-cycle pulses are caught here, so the bench never races for them
    always @(posedge I_CLK)
    begin
        relock_seen <= relock_seen | O_PLL_RELOCK;
        pd_seen <= pd_seen | O_PLL_OUT_PD;
    end
    always @(posedge hung)
    begin
        mismatches++;
        give_verdict;
    end
    task automatic settle; repeat (6) @(posedge I_CLK); endtask
    // Expected sticky readback of group k after live value v
    function automatic logic [7:0] exp_sticky(int k, logic [7:0] v);
        case (k)
            0: return 8'h04;
            2: return {4'h0, v[3:0]};
            default: return v;
        endcase
    endfunction
    function automatic logic [3:0] exp_relock(int n);
        return 4'((2 << n) - 1);
    endfunction
    task automatic drive(int k, logic [7:0] v);
        case (k)
            0: {I_XTAL_LOSS, I_INT_OSC_LOSS} <= (v == 8'h00) ? 2'b00 : {v[0], !v[0]};
            1: {I_PLL_HOLDOVER, I_PLL_UNLOCK} <= v;
            2: I_INPUT_CLOCK_LOSS <= v[3:0];
            default: I_FREQ_DRIFT <= v;
        endcase
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(47));
        repeat (8) @(posedge I_CLK);
        I_NRST <= 1'b1;
        @(posedge I_CLK);
        u_host.xfer(1'b0, 8'h04, 8'hff, 4'h0, q);
        u_host.rd(8'h04, q);
        `CHK("mask without strobe", 8'h00, q)
        u_host.rd(8'h10, q);
        `CHK("unmapped read", 8'h00, q)
        for (g = 0; g < 4; g++)
        begin
            ad = g[0] ? 8'h07 : 8'h03;
            ev = 8'($urandom_range(255, 1)) | ((g == 2) ? 8'h01 : 8'h00);
            ex = exp_sticky(g, ev);
            drive(g, ev);
            settle;
            `CHK("lock pins", (g == 1) ? ~ev[3:0] : 4'hf, lock_pins)
            `CHK("any unlock", !(g == 1 && ev[3:0] != 4'h0), O_ANY_UNLOCK_N)
            `CHK("osc loss pin", g != 0, O_OSC_PATH_LOSS_N)
            drive(g, 8'h00);
            settle;
            u_host.wr(8'hff, 8'(g >> 1));
            u_host.rd(ad, q);
            `CHK("sticky", ex, q)
            `CHK("intr masked", 1'b1, O_INTR_N)
            u_host.wr(ad + 8'h01, 8'hff);
            settle;
            `CHK("intr set", 1'b0, O_INTR_N)
            u_host.wr(ad, 8'h00);
            u_host.rd(ad, q);
            `CHK("zero write", ex, q)
            drive(g, ev);
            settle;
            // A lost set would release the pin for one cycle
            blip = 1'b0;
            fork
                u_host.wr(ad, ex);
                repeat (6) @(posedge I_CLK) blip = blip | O_INTR_N;
            join
            u_host.rd(ad, q);
            `CHK("set wins", ex, q)
            `CHK("set wins intr", 1'b0, blip)
            u_host.rd(8'h02, q);
            if (g == 2) `CHK("live loss", ev[3:0], q[3:0])
            drive(g, 8'h00);
            settle;
            u_host.clear_all;
            settle;
            `CHK("intr cleared", 1'b1, O_INTR_N)
            u_host.wr(8'hff, 8'(g >> 1));
            u_host.rd(ad, q);
            `CHK("cleared", 8'h00, q)
            u_host.wr(ad + 8'h01, 8'h00);
            $display("notify group %0d done", g);
        end
        I_INPUT_SUPPLY_DIP <= 1'b1;
        settle;
        u_host.wr(8'hff, 8'h00);
        u_host.rd(8'h02, q);
        `CHK("input dip", 1'b1, q[1])
        u_host.wr(8'hff, 8'h0c);
        u_host.rd(8'h02, q);
        `CHK("core ok", 1'b0, q[2])
        I_CORE_SUPPLY_DIP <= 1'b1;
        settle;
        u_host.rd(8'h02, q);
        `CHK("core dip pll", 1'b1, q[2])
        u_host.wr(8'hff, 8'h03);
        u_host.rd(8'h02, q);
        `CHK("core dip p3", 1'b1, q[0])
        u_host.rd(8'hff, q);
        `CHK("page readback", 8'h03, q)
        $display("supply test done");
        for (p = 0; p < 4; p++)
        begin
            pd = $urandom_range(1, 0);
            pdx = pdx | (pd[0] ? 4'(1 << p) : 4'h0);
            u_host.relock(8'h0a + 8'(p), pd[0]);
            settle;
            `CHK("relock pulses", exp_relock(p), relock_seen)
            `CHK("power down seen", pdx, pd_seen)
            `CHK("power restored", 4'h0, O_PLL_OUT_PD)
        end
        $display("relock test done");
        give_verdict;
    end
endmodule
`default_nettype wire
